/* hw/tuc_defines.svh */
`ifndef TUC_DEFINES_SVH
`define TUC_DEFINES_SVH

`define TUC_ADDR_CTRL      12'h000
`define TUC_ADDR_COUNT     12'h004

`define TUC_BIT_RUN        15
`define TUC_BIT_IDLE       13
`define TUC_BIT_GATE       6
`define TUC_BIT_PS_HI      5
`define TUC_BIT_PS_LO      4
`define TUC_BIT_CSEL       1

`define TUC_CTRL_MASK      16'hA072
`define TUC_CTRL_RESET     16'h0000
`define TUC_COUNT_RESET    16'h0000

`define TUC_PS_LAST_1      8'h00
`define TUC_PS_LAST_8      8'h07
`define TUC_PS_LAST_64     8'h3F
`define TUC_PS_LAST_256    8'hFF

`define TUC_SYNC_FILL      2'h3

`endif

/* hw/tuc_pkg.sv */
package tuc_pkg;

    typedef enum logic [1:0] {
        TUC_PS_DIV1   = 2'h0,
        TUC_PS_DIV8   = 2'h1,
        TUC_PS_DIV64  = 2'h2,
        TUC_PS_DIV256 = 2'h3
    } tuc_ps_e;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [7:0]  presc;
        logic [15:0] count;
        logic        extMeta;
        logic        extSync;
        logic        extPrev;
        logic        gateMeta;
        logic        gateSync;
        logic [1:0]  extFill;
        logic        rdReady;
        logic [31:0] rdata;
    } tuc_state_s;

endpackage

/* hw/tuc_timer.sv */
`timescale 1ns/1ps
`include "tuc_defines.svh"

module tuc_timer
    import tuc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        clkEn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        idleMode,
    input  wire logic        pairMode32,
    input  wire logic        extCountPin,
    input  wire logic        gatePin,
    output logic      [15:0] countValue,
    output logic             timerActive
);

    tuc_state_s s;
    tuc_state_s next_s;

    logic        ctrlHit;
    logic        countHit;
    logic        access;
    logic        ctrlWrite;
    logic        countWrite;
    logic        extEdge;
    logic        srcTick;
    logic        active;
    tuc_ps_e     psSel;

    function automatic logic [7:0] tucLastCount(input tuc_ps_e ps);
        case (ps)
            TUC_PS_DIV1:   tucLastCount = `TUC_PS_LAST_1;
            TUC_PS_DIV8:   tucLastCount = `TUC_PS_LAST_8;
            TUC_PS_DIV64:  tucLastCount = `TUC_PS_LAST_64;
            TUC_PS_DIV256: tucLastCount = `TUC_PS_LAST_256;
            default:       tucLastCount = `TUC_PS_LAST_1;
        endcase
    endfunction

    assign ctrlHit    = (paddr == `TUC_ADDR_CTRL);
    assign countHit   = (paddr == `TUC_ADDR_COUNT);
    // Transfers stall while the block is frozen, so nothing is lost; a read
    // also waits for its captured data, which costs one extra cycle only
    // when a freeze swallowed the setup edge
    assign pready     = clkEn & (pwrite | s.rdReady);
    assign access     = psel & penable & pready;
    assign pslverr    = access & ~(ctrlHit | countHit);
    assign ctrlWrite  = access & pwrite & ctrlHit;
    assign countWrite = access & pwrite & countHit;
    assign prdata     = s.rdata;
    assign countValue = s.count;
    assign timerActive = active;

    assign psSel   = tuc_ps_e'(s.ctrl[`TUC_BIT_PS_HI:`TUC_BIT_PS_LO]);
    // Edge taken from the second and third stages, never the first; ignored until
    // the chain holds real pin samples, or a pin idling high would fake an edge
    assign extEdge = s.extSync & ~s.extPrev & (s.extFill == `TUC_SYNC_FILL);
    always_comb begin
        if (s.ctrl[`TUC_BIT_CSEL]) begin
            srcTick = extEdge;
        end else if (s.ctrl[`TUC_BIT_GATE]) begin
            srcTick = s.gateSync;
        end else begin
            srcTick = 1'b1;
        end
    end

    // Lower timer owns the pair in 32-bit mode
    assign active = s.ctrl[`TUC_BIT_RUN]
                  & ~(s.ctrl[`TUC_BIT_IDLE] & idleMode)
                  & ~pairMode32;

    always_comb begin
        next_s          = s;
        next_s.extMeta  = extCountPin;
        next_s.extSync  = s.extMeta;
        next_s.extPrev  = s.extSync;
        next_s.gateMeta = gatePin;
        next_s.gateSync = s.gateMeta;
        if (s.extFill != `TUC_SYNC_FILL) begin
            next_s.extFill = s.extFill + 2'h1;
        end

        if (active && srcTick) begin
            if (s.presc >= tucLastCount(psSel)) begin
                next_s.presc = 8'h00;
                next_s.count = s.count + 16'h0001;
            end else begin
                next_s.presc = s.presc + 8'h01;
            end
        end

        if (ctrlWrite) begin
            next_s.ctrl = pwdata[15:0] & `TUC_CTRL_MASK;
            if (s.ctrl[`TUC_BIT_RUN]) begin
                next_s.presc = 8'h00;
            end
        end

        // Software load wins over a tick in the same cycle
        if (countWrite) begin
            next_s.count = pwdata[15:0];
        end

        // Completing access consumes the captured read data
        if (access) begin
            next_s.rdReady = 1'b0;
        end

        // Read data captured in setup so it stands through the access phase;
        // a setup edge lost to a freeze is made up in the first access cycle
        if (psel && !pwrite && !s.rdReady) begin
            next_s.rdReady = 1'b1;
            if (ctrlHit) begin
                next_s.rdata = {16'h0000, s.ctrl & `TUC_CTRL_MASK};
            end else if (countHit) begin
                next_s.rdata = {16'h0000, s.count};
            end else begin
                next_s.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s.ctrl     <= `TUC_CTRL_RESET;
            s.presc    <= 8'h00;
            s.count    <= `TUC_COUNT_RESET;
            s.extMeta  <= 1'b0;
            s.extSync  <= 1'b0;
            s.extPrev  <= 1'b0;
            s.gateMeta <= 1'b0;
            s.gateSync <= 1'b0;
            s.rdata    <= 32'h0000_0000;
            s.extFill  <= 2'h0;
            s.rdReady  <= 1'b0;
        end else if (clkEn) begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (!arst_n);

    sequence sCtrlWrite;
        psel && !penable && pwrite && ctrlHit
        ##1 psel && penable && pready && pwrite && ctrlHit;
    endsequence

    sequence sCtrlRead;
        psel && !penable && !pwrite && ctrlHit && clkEn
        ##1 psel && penable && pready;
    endsequence

    sequence sCountRead;
        psel && !penable && !pwrite && countHit && clkEn
        ##1 psel && penable && pready;
    endsequence

    sequence sBadRead;
        psel && !penable && !pwrite && !ctrlHit && !countHit && clkEn
        ##1 psel && penable && pready;
    endsequence

    a_stop_holds: assert property (
        (clkEn && !s.ctrl[`TUC_BIT_RUN] && !countWrite) |=> $stable(s.count)
    ) else $error("count moved while stopped");

    a_idle_halt: assert property (
        (clkEn && s.ctrl[`TUC_BIT_IDLE] && idleMode && !countWrite)
        |=> $stable(s.count)
    ) else $error("count moved in idle with halt set");

    a_plain_count: assert property (
        (clkEn && active && !s.ctrl[`TUC_BIT_CSEL] && !s.ctrl[`TUC_BIT_GATE]
         && psSel == TUC_PS_DIV1 && !countWrite && !ctrlWrite)
        |=> (s.count == $past(s.count) + 16'h0001)
    ) else $error("1:1 internal count did not advance");

    a_gate_block: assert property (
        (clkEn && !s.ctrl[`TUC_BIT_CSEL] && s.ctrl[`TUC_BIT_GATE]
         && !s.gateSync && !countWrite && !ctrlWrite)
        |=> $stable(s.count) && $stable(s.presc)
    ) else $error("gated count moved with gate low");

    a_ext_gate_free: assert property (
        (clkEn && active && s.ctrl[`TUC_BIT_CSEL] && s.ctrl[`TUC_BIT_GATE]
         && extEdge && psSel == TUC_PS_DIV1 && !countWrite && !ctrlWrite)
        |=> (s.count == $past(s.count) + 16'h0001)
    ) else $error("gate bit affected external counting");

    a_ext_no_edge: assert property (
        (clkEn && s.ctrl[`TUC_BIT_CSEL] && !extEdge && !countWrite && !ctrlWrite)
        |=> $stable(s.count) && $stable(s.presc)
    ) else $error("external count moved without an edge");

    a_presc_clear: assert property (
        (clkEn && ctrlWrite && s.ctrl[`TUC_BIT_RUN]) |=> (s.presc == 8'h00)
    ) else $error("prescaler not cleared by control write");

    a_presc_bound: assert property (
        (clkEn && !ctrlWrite) |=> (s.presc <= tucLastCount($past(psSel)))
    ) else $error("prescaler passed its divide limit");

    a_ctrl_store: assert property (
        sCtrlWrite |=> (s.ctrl == ($past(pwdata[15:0]) & `TUC_CTRL_MASK))
    ) else $error("control write stored wrong bits");

    a_read_zero: assert property (
        sCtrlRead |-> ((prdata & ~{16'h0000, `TUC_CTRL_MASK}) == 32'h0000_0000)
    ) else $error("unimplemented control bits read nonzero");

    a_pair_ignore: assert property (
        (clkEn && pairMode32 && !countWrite) |=> $stable(s.count)
    ) else $error("count moved in 32-bit pair mode");

    a_reset_clear: assert property (
        disable iff (1'b0)
        !arst_n |-> (s.ctrl == `TUC_CTRL_RESET && !timerActive)
    ) else $error("control not cleared by reset");

    a_reset_count: assert property (
        disable iff (1'b0)
        !arst_n |-> (s.count == `TUC_COUNT_RESET && s.presc == 8'h00 && !s.rdReady)
    ) else $error("count or prescaler not cleared by reset");

    a_active_out: assert property (
        timerActive |-> s.ctrl[`TUC_BIT_RUN]
    ) else $error("timer active with run bit clear");

    a_gate_count: assert property (
        (clkEn && active && !s.ctrl[`TUC_BIT_CSEL] && s.ctrl[`TUC_BIT_GATE]
         && s.gateSync && psSel == TUC_PS_DIV1 && !countWrite && !ctrlWrite)
        |=> (s.count == $past(s.count) + 16'h0001)
    ) else $error("gated count missed a high gate cycle");

    a_ext_count: assert property (
        (clkEn && active && s.ctrl[`TUC_BIT_CSEL] && !s.ctrl[`TUC_BIT_GATE]
         && extEdge && psSel == TUC_PS_DIV1 && !countWrite && !ctrlWrite)
        |=> (s.count == $past(s.count) + 16'h0001)
    ) else $error("external edge was not counted");

    a_idle_run: assert property (
        (clkEn && s.ctrl[`TUC_BIT_RUN] && !s.ctrl[`TUC_BIT_IDLE] && idleMode
         && !pairMode32 && !s.ctrl[`TUC_BIT_CSEL] && !s.ctrl[`TUC_BIT_GATE]
         && psSel == TUC_PS_DIV1 && !countWrite && !ctrlWrite)
        |=> (s.count == $past(s.count) + 16'h0001)
    ) else $error("count stalled in idle with halt clear");

    a_presc_step: assert property (
        (clkEn && active && srcTick && s.presc < tucLastCount(psSel) && !ctrlWrite)
        |=> (s.presc == $past(s.presc) + 8'h01)
    ) else $error("prescaler did not step on a tick");

    a_presc_wrap: assert property (
        (clkEn && active && srcTick && s.presc >= tucLastCount(psSel)
         && !ctrlWrite && !countWrite)
        |=> (s.presc == 8'h00 && s.count == $past(s.count) + 16'h0001)
    ) else $error("prescaler wrap did not advance the count");

    // Stopped rewrites keep the prescaler, so software can retune it safely
    a_stop_keep: assert property (
        (clkEn && ctrlWrite && !s.ctrl[`TUC_BIT_RUN]) |=> $stable(s.presc)
    ) else $error("prescaler moved on a stopped control write");

    a_count_load: assert property (
        countWrite |=> (s.count == $past(pwdata[15:0]))
    ) else $error("count write did not load the count");

    a_freeze_holds: assert property (
        !clkEn |=> $stable(s)
    ) else $error("state moved while the clock enable was low");

    a_freeze_stall: assert property (
        !clkEn |-> !pready
    ) else $error("bus answered while frozen");

    a_count_read: assert property (
        sCountRead |-> (prdata == {16'h0000, $past(s.count)})
    ) else $error("count read returned a stale value");

    a_ctrl_read: assert property (
        sCtrlRead |-> (prdata == {16'h0000, $past(s.ctrl) & `TUC_CTRL_MASK})
    ) else $error("control read returned wrong bits");

    a_bad_read: assert property (
        sBadRead |-> (prdata == 32'h0000_0000 && pslverr)
    ) else $error("unmapped read not refused");

endmodule

/* dv/tuc_timer_test.sv */
`timescale 1ns/1ps
`include "tuc_defines.svh"

module tuc_timer_test
    import tuc_pkg::*;
;
    logic        clk = 1'b0;
    logic        arstN = 1'b1;
    logic        clkEn = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        idleMode = 1'b0;
    logic        pairMode32 = 1'b0;
    logic        extCountPin = 1'b0;
    logic        gatePin = 1'b0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [15:0] countValue;
    wire         timerActive;
    logic [31:0] rd;
    logic        er;
    logic [15:0] cnt;
    int          errTotal = 0;
    int          compares = 0;
    int          div [4] = '{1, 8, 64, 256};

    always #25 clk = ~clk;

    // Clock enable is driven so the freeze and stall paths are exercised
    tuc_timer i_dut (.clk(clk), .arst_n(arstN), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .idleMode(idleMode), .pairMode32(pairMode32),
        .extCountPin(extCountPin), .gatePin(gatePin), .countValue(countValue),
        .timerActive(timerActive));

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED at %0t: %s got %h", $time, m, got);
        end
    endtask

    task automatic chkRng(input logic [15:0] got, input int lo, input int hi, input string m);
        compares++;
        if ((^got === 1'bx) || got < lo || got > hi) begin
            errTotal++;
            $display("CHECK FAILED at %0t: %s got %0d", $time, m, got);
        end
    endtask

    // Pulses are slow enough to survive the pin synchroniser
    task automatic run(input logic [15:0] c, input int cyc, input int pulses);
        apb(1'b1, `TUC_ADDR_COUNT, 32'h0000_0000);
        apb(1'b1, `TUC_ADDR_CTRL, {16'h0000, c});
        repeat (cyc) @(posedge clk);
        repeat (pulses) begin
            @(posedge clk) extCountPin <= 1'b1;
            repeat (4) @(posedge clk);
            extCountPin <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (pulses > 0 ? 6 : 0) @(posedge clk);
        apb(1'b1, `TUC_ADDR_CTRL, 32'h0000_0000);
        apb(1'b0, `TUC_ADDR_COUNT, 32'h0000_0000);
        cnt = rd[15:0];
    endtask

    task automatic wrapUp();
        $display("Counts: %0d compares, %0d mismatches", compares, errTotal);
        if (errTotal == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        errTotal++;
        $display("CHECK FAILED at %0t: watchdog", $time);
        wrapUp();
    end

    initial begin
        arstN <= 1'b0;
        repeat (3) @(posedge clk);
        arstN <= 1'b1;
        apb(1'b0, `TUC_ADDR_CTRL, 32'h0000_0000);
        chkVal(rd, 32'h0000_0000, "ctrl reset");
        apb(1'b1, `TUC_ADDR_CTRL, 32'h0000_FFFF);
        apb(1'b0, `TUC_ADDR_CTRL, 32'h0000_0000);
        chkVal(rd, 32'h0000_A072, "ctrl readback");
        apb(1'b0, 12'h008, 32'h0000_0000);
        chkVal({31'h0000_0000, er}, 32'h0000_0001, "unmapped error");
        chkVal(rd, 32'h0000_0000, "unmapped data");
        $display("test registers done");
        for (int p = 0; p < 4; p++) begin
            run(16'h8000 | 16'(p << 4), 4 * div[p], 0);
            chkRng(cnt, 4, (4 * div[p] + 3) / div[p], "prescale");
        end
        repeat (20) @(posedge clk);
        apb(1'b0, `TUC_ADDR_COUNT, 32'h0000_0000);
        chkVal(rd, {16'h0000, cnt}, "stopped holds");
        run(16'h0000, 50, 0);
        chkRng(cnt, 0, 0, "run off");
        idleMode <= 1'b1;
        run(16'hA000, 50, 0);
        chkRng(cnt, 0, 0, "idle halt");
        run(16'h8000, 50, 0);
        chkRng(cnt, 50, 53, "idle run");
        idleMode   <= 1'b0;
        pairMode32 <= 1'b1;
        run(16'h8000, 50, 0);
        chkRng(cnt, 0, 0, "pair mode");
        pairMode32 <= 1'b0;
        run(16'h8040, 50, 0);
        chkRng(cnt, 0, 0, "gate low");
        gatePin <= 1'b1;
        run(16'h8040, 50, 0);
        chkRng(cnt, 48, 53, "gate high");
        gatePin <= 1'b0;
        run(16'h8042, 10, 5);
        chkRng(cnt, 5, 5, "ext edges");
        run(16'h8002, 50, 0);
        chkRng(cnt, 0, 0, "ext quiet");
        run(16'h8002, 10, 3);
        chkRng(cnt, 3, 3, "ext plain");
        $display("test modes done");
        // Freeze: state holds and the bus stalls while the enable is low
        apb(1'b1, `TUC_ADDR_COUNT, 32'h0000_0000);
        apb(1'b1, `TUC_ADDR_CTRL, 32'h0000_8000);
        @(negedge clk);
        chkVal({31'h0000_0000, timerActive}, 32'h0000_0001, "run active");
        @(posedge clk) clkEn <= 1'b0;
        repeat (20) @(negedge clk);
        chkVal({16'h0000, countValue}, 32'h0000_0001, "frozen count");
        chkVal({31'h0000_0000, pready}, 32'h0000_0000, "frozen stall");
        @(posedge clk) clkEn <= 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        chkVal({16'h0000, countValue}, 32'h0000_000B, "thawed count");
        @(posedge clk) idleMode <= 1'b1;
        apb(1'b1, `TUC_ADDR_CTRL, 32'h0000_A000);
        @(negedge clk);
        chkVal({31'h0000_0000, timerActive}, 32'h0000_0000, "idle inactive");
        apb(1'b1, `TUC_ADDR_CTRL, 32'h0000_0000);
        idleMode <= 1'b0;
        $display("test freeze done");
        // Rewrites come faster than one 1:8 period, so the count must never move
        apb(1'b1, `TUC_ADDR_COUNT, 32'h0000_0000);
        apb(1'b1, `TUC_ADDR_CTRL, 32'h0000_8010);
        repeat (10) begin
            repeat (4) @(posedge clk);
            apb(1'b1, `TUC_ADDR_CTRL, 32'h0000_8010);
        end
        apb(1'b1, `TUC_ADDR_CTRL, 32'h0000_0000);
        apb(1'b0, `TUC_ADDR_COUNT, 32'h0000_0000);
        chkVal(rd, 32'h0000_0000, "prescaler clear");
        $display("test prescaler clear done");
        wrapUp();
    end
endmodule
